// ===== src/emc_defines.svh
// Purpose: offsets, field positions and reset values of the mac control block
// Assumes: 32-bit apb, one aligned word per register
// Notes:   included by its bare name
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EMC_OFF_ECTRL      12'h000
`define EMC_OFF_DMA_CONTROL_REG    12'h004
`define EMC_OFF_TRANSMIT_CONTROL_REG      12'h008
`define EMC_OFF_PTV        12'h00c
`define EMC_OFF_TRANSMIT_STATUS_REG      12'h010
`define EMC_OFF_INTERRUPT_EVENT_REG     12'h014
`define EMC_OFF_CARRY1     12'h018
`define EMC_OFF_CARRY2     12'h01c
`define EMC_OFF_CNT_BASE   12'h100

// ----------------------------------------
// field positions
// ----------------------------------------
`define EMC_ECTRL_CLR      12
`define EMC_ECTRL_AUTO_ZERO_ON_READ    11
`define EMC_ECTRL_GMII     5
`define EMC_ECTRL_TBI      4
`define EMC_ECTRL_RPM      2
`define EMC_ECTRL_R100     1
`define EMC_ECTRL_RMII     0
`define EMC_DMA_GTS        3
`define EMC_DMA_TOD        2
`define EMC_TRANSMIT_CONTROL_REG_PAUSE    4
`define EMC_EV_TXC         0
`define EMC_EV_CRL         1
`define EMC_EV_STATS_OVERFLOW_EVENT        2
`define EMC_EV_MGMT_WRITE_DONE_EVENT        3
`define EMC_EV_MGMT_READ_DONE_EVENT        4
`define EMC_PTV_W          16

`define EMC_ECTRL_RST      32'h0000_0000
`define EMC_PTV_RST        16'h0000

`endif

// ===== src/emc_pkg.sv
// Purpose: types shared by the mac control block
// Assumes: nothing beyond the defines header
// Notes:   none
package emc_pkg;
  typedef enum logic [3:0] {
    EMC_TX_IDLE  = 4'b0001,
    EMC_TX_DATA  = 4'b0010,
    EMC_TX_PAUSE = 4'b0100,
    EMC_TX_HALT  = 4'b1000
  } emc_tx_state_t;

  typedef struct packed {
    logic        start;
    logic        is_pause;
    logic [15:0] pause_time;
  } emc_tx_cmd_t;

  typedef struct packed {
    logic done;
    logic retry_limit;
  } emc_tx_rsp_t;
endpackage

// ===== src/emc_stat_counters.sv
// Purpose: statistics counters with carry flags, clear and auto-zero on read
// Assumes: one increment pulse per counter per cycle at most
// Notes:   carry flags split across two words, low half and high half
`timescale 1ns/1ps
`include "emc_defines.svh"
module emc_stat_counters import emc_pkg::*; #(
  parameter int NCNT  = 8,
  parameter int CNT_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [NCNT-1:0]   inc,
  input  wire logic              clear_all,
  input  wire logic              auto_zero,
  input  wire logic [NCNT-1:0]   rd_hit,
  input  wire logic [NCNT-1:0]   wr_hit,
  input  wire logic [CNT_W-1:0]  wr_data,
  input  wire logic [NCNT-1:0]   carry_w1c,
  output logic [NCNT*CNT_W-1:0]  cnt_flat,
  output logic [NCNT-1:0]        carry_ff,
  output logic                   overflow
);
  logic [CNT_W-1:0] cnt_ff [NCNT];
  logic [NCNT-1:0]  wrap;

  genvar g;
  for (g = 0; g < NCNT; g++) begin : g_cnt
    assign wrap[g] = inc[g] && (cnt_ff[g] == {CNT_W{1'b1}});
    assign cnt_flat[g*CNT_W +: CNT_W] = cnt_ff[g];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff[g] <= '0;
      end else if (clear_all) begin
        cnt_ff[g] <= '0; // [R3]
      end else if (wr_hit[g]) begin
        cnt_ff[g] <= wr_data; // [R6]
      end else if (rd_hit[g] && auto_zero) begin
        cnt_ff[g] <= inc[g] ? CNT_W'(1) : '0; // [R5]
      end else if (inc[g]) begin
        cnt_ff[g] <= cnt_ff[g] + CNT_W'(1); // [R4]
      end
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        carry_ff[g] <= 1'b0;
      end else if (clear_all) begin
        carry_ff[g] <= 1'b0; // [R3]
      end else if (wrap[g]) begin
        carry_ff[g] <= 1'b1; // [R21]
      end else if (carry_w1c[g]) begin
        carry_ff[g] <= 1'b0; // [R8]
      end
    end
  end

  assign overflow = |wrap;
endmodule

// ===== src/emc_tx_sched.sv
// Purpose: transmit scheduler: data frames, requested pause frames, halts
// Assumes: mac answers each start with exactly one done or retry_limit pulse
// Notes:   a frame in flight always ends, with done or retry_limit, before a pause frame goes out
`timescale 1ns/1ps
`include "emc_defines.svh"
module emc_tx_sched import emc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        data_ready,
  input  wire logic        tx_stop,
  input  wire logic        pause_req,
  input  wire logic [15:0] pause_time,
  input  wire logic        halt_clr,
  input  wire emc_tx_rsp_t rsp,
  output emc_tx_cmd_t      cmd_ff,
  output logic             pause_sent,
  output logic             retry_abort,
  output logic             halted
);
  emc_tx_state_t state_ff;
  emc_tx_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EMC_TX_IDLE: begin
        if (pause_req) begin
          nxt_state = EMC_TX_PAUSE; // [R11] [R14]
        end else if (data_ready && !tx_stop) begin
          nxt_state = EMC_TX_DATA;
        end
      end
      EMC_TX_DATA: begin
        if (rsp.retry_limit) begin
          nxt_state = EMC_TX_HALT; // [R16]
        end else if (rsp.done) begin
          nxt_state = EMC_TX_IDLE; // [R10]
        end
      end
      EMC_TX_PAUSE: begin
        if (rsp.done || rsp.retry_limit) begin
          nxt_state = EMC_TX_IDLE; // [R13]
        end
      end
      EMC_TX_HALT: begin
        if (pause_req) begin
          nxt_state = EMC_TX_PAUSE; // [R14]
        end else if (halt_clr) begin
          nxt_state = EMC_TX_IDLE;
        end
      end
      default: nxt_state = EMC_TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= EMC_TX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff.start      <= (state_ff != nxt_state) &&
                           (nxt_state == EMC_TX_DATA || nxt_state == EMC_TX_PAUSE);
      cmd_ff.is_pause   <= (nxt_state == EMC_TX_PAUSE);
      if (nxt_state == EMC_TX_PAUSE && state_ff != EMC_TX_PAUSE) begin
        cmd_ff.pause_time <= pause_time; // [R11]
      end
    end
  end

  assign pause_sent  = (state_ff == EMC_TX_PAUSE) && rsp.done; // [R12]
  assign retry_abort = (state_ff == EMC_TX_DATA) && rsp.retry_limit;
  assign halted      = (state_ff == EMC_TX_HALT);
endmodule

// ===== src/emc_mac_ctrl.sv
// Purpose: apb register file and control of the mac: mode bits, counters, pause, halt
// Assumes: apb 32-bit, zero wait states; mac frame engine outside this block
// Notes:   unmapped addresses read zero and answer pslverr
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "emc_defines.svh"

// Notes on behaviour
// [R1] software never sets reduced mii mode together with reduced pin mode
// [R2] reduced mii mode bit: 0 non-rmii interface, 1 rmii interface
// [R3] clear command resets all counters and carry flags, then self-clears
// [R4] without clear command counters keep counting and carry flags stay
// [R5] auto zero set: counter cleared right after a host read of it
// [R6] auto zero clear: software writes zero to restart a counter
// [R7] software sets auto zero before enabling mac, then leaves it static
// [R8] carry flag registers are write-one-to-clear
// [R9] transmit on demand starts descriptor fetch from ring 0 at once
// [R10] pause request lets current frame finish, then stops data frames
// [R11] then a pause frame carries the programmed pause time
// [R12] control frame sent event rises when that pause frame completes
// [R13] after the pause frame request self-clears and data resumes
// [R14] pause frame still sent during graceful stop or received pause
// [R15] request bit reads 1 while pending, 0 when idle or done
// [R16] retry limit: frame dropped, queue halted, halted flag set
// [R17] overflow and management done events form a special-function class
// [R18] receive error input ignored in rgmii and rtbi modes
// [R19] software sets gigabit mii mode only for gmii at 1 gbps
// [R20] unsupported tbi or rmii variants make those mode bits inert
// [R21] counter wrap sets its carry flag until cleared
module emc_mac_ctrl import emc_pkg::*; #(
  parameter int NCNT        = 8,
  parameter int CNT_W       = 32,
  parameter bit HAS_TBI     = 1'b1,
  parameter bit HAS_RMII    = 1'b1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCNT-1:0]  stat_inc,
  input  wire logic             tx_data_ready,
  input  wire emc_tx_rsp_t      tx_rsp,
  input  wire logic             rx_pause_active,
  input  wire logic             mgmt_write_done,
  input  wire logic             mgmt_read_done,
  input  wire logic             receive_error_input,
  input  wire logic             rgmii_or_rtbi,
  output emc_tx_cmd_t           tx_cmd,
  output logic                  tx_bd_fetch,
  output logic                  tx_halted,
  output logic                  rmii_select,
  output logic                  tbi_select,
  output logic                  gmii_select,
  output logic                  rx_error_seen,
  output logic                  special_event
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        acc;
  logic        wr;
  logic        rd;
  logic        cnt_sel;
  logic [2:0]  cnt_idx;
  logic        mapped;

  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign pready  = 1'b1;
  assign cnt_sel = (paddr[11:8] == 4'(`EMC_OFF_CNT_BASE >> 8)) &&
                   (paddr[7:2] < 6'(NCNT)) &&
                   (paddr[1:0] == 2'b00);
  assign cnt_idx = paddr[4:2];

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [31:0] ectrl_ff;
  logic        gts_ff;
  logic        tod_ff;
  logic        pause_req_ff;
  logic [15:0] ptv_ff;
  logic        halted_clr;
  logic        pause_sent;
  logic        retry_abort;
  logic        clr_cmd;

  assign clr_cmd = ectrl_ff[`EMC_ECTRL_CLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ectrl_ff <= `EMC_ECTRL_RST;
    end else if (wr && paddr == `EMC_OFF_ECTRL) begin
      ectrl_ff <= pwdata;
    end else begin
      ectrl_ff[`EMC_ECTRL_CLR] <= 1'b0; // [R3]
    end
  end

  // reduced mii only takes effect when rmii exists and reduced pin mode is off
  assign rmii_select = HAS_RMII && ectrl_ff[`EMC_ECTRL_RMII] && !ectrl_ff[`EMC_ECTRL_RPM]; // [R1] [R2] [R20]
  assign tbi_select  = HAS_TBI && ectrl_ff[`EMC_ECTRL_TBI]; // [R20]
  assign gmii_select = ectrl_ff[`EMC_ECTRL_GMII]; // [R19]
  assign rx_error_seen = receive_error_input && !rgmii_or_rtbi; // [R18]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gts_ff <= 1'b0;
      tod_ff <= 1'b0;
    end else if (wr && paddr == `EMC_OFF_DMA_CONTROL_REG) begin
      gts_ff <= pwdata[`EMC_DMA_GTS];
      tod_ff <= pwdata[`EMC_DMA_TOD]; // [R9]
    end else begin
      tod_ff <= 1'b0;
    end
  end

  // one-cycle fetch pulse, no polling interval in between
  assign tx_bd_fetch = tod_ff; // [R9]

  // hardware clear wins only when no new software set arrives in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_req_ff <= 1'b0;
    end else if (wr && paddr == `EMC_OFF_TRANSMIT_CONTROL_REG && pwdata[`EMC_TRANSMIT_CONTROL_REG_PAUSE]) begin
      pause_req_ff <= 1'b1; // [R10]
    end else if (pause_sent) begin
      pause_req_ff <= 1'b0; // [R13] [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptv_ff <= `EMC_PTV_RST;
    end else if (wr && paddr == `EMC_OFF_PTV) begin
      ptv_ff <= pwdata[`EMC_PTV_W-1:0];
    end
  end

  // ----------------------------------------
  // transmit status and events
  // ----------------------------------------
  logic       halted_ff;
  logic [4:0] interrupt_event_reg_ff;
  logic [4:0] ev_set;
  logic       ovf;
  logic       sched_halted;

  assign halted_clr = wr && paddr == `EMC_OFF_TRANSMIT_STATUS_REG && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_ff <= 1'b0;
    end else if (retry_abort) begin
      halted_ff <= 1'b1; // [R16]
    end else if (halted_clr) begin
      halted_ff <= 1'b0;
    end
  end
  assign tx_halted = halted_ff;

  assign ev_set[`EMC_EV_TXC]  = pause_sent; // [R12]
  assign ev_set[`EMC_EV_CRL]  = retry_abort; // [R16]
  assign ev_set[`EMC_EV_STATS_OVERFLOW_EVENT] = ovf;
  assign ev_set[`EMC_EV_MGMT_WRITE_DONE_EVENT] = mgmt_write_done;
  assign ev_set[`EMC_EV_MGMT_READ_DONE_EVENT] = mgmt_read_done;

  genvar e;
  for (e = 0; e < 5; e++) begin : g_ev
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        interrupt_event_reg_ff[e] <= 1'b0;
      end else if (ev_set[e]) begin
        interrupt_event_reg_ff[e] <= 1'b1;
      end else if (wr && paddr == `EMC_OFF_INTERRUPT_EVENT_REG && pwdata[e]) begin
        interrupt_event_reg_ff[e] <= 1'b0;
      end
    end
  end

  // special-function class reported as one level of its own
  assign special_event = interrupt_event_reg_ff[`EMC_EV_STATS_OVERFLOW_EVENT] | interrupt_event_reg_ff[`EMC_EV_MGMT_WRITE_DONE_EVENT] | interrupt_event_reg_ff[`EMC_EV_MGMT_READ_DONE_EVENT]; // [R17]

  // ----------------------------------------
  // counters and scheduler
  // ----------------------------------------
  logic [NCNT*CNT_W-1:0] cnt_flat;
  logic [NCNT-1:0]       carry;
  logic [NCNT-1:0]       cnt_rd;
  logic [NCNT-1:0]       cnt_wr;
  logic [NCNT-1:0]       carry_w1c;

  for (e = 0; e < NCNT; e++) begin : g_hit
    assign cnt_rd[e]    = rd && cnt_sel && cnt_idx == 3'(e);
    assign cnt_wr[e]    = wr && cnt_sel && cnt_idx == 3'(e);
    // low half of the counters in the first carry word, high half in the second
    if (e < NCNT/2) begin : g_lo
      assign carry_w1c[e] = wr && paddr == `EMC_OFF_CARRY1 && pwdata[e];
    end else begin : g_hi
      assign carry_w1c[e] = wr && paddr == `EMC_OFF_CARRY2 && pwdata[e - NCNT/2];
    end
  end

  emc_stat_counters #(
    .NCNT  (NCNT),
    .CNT_W (CNT_W)
  ) u_cnt (
    .pclk      (pclk),
    .presetn   (presetn),
    .inc       (stat_inc),
    .clear_all (clr_cmd),
    .auto_zero (ectrl_ff[`EMC_ECTRL_AUTO_ZERO_ON_READ]),
    .rd_hit    (cnt_rd),
    .wr_hit    (cnt_wr),
    .wr_data   (pwdata[CNT_W-1:0]),
    .carry_w1c (carry_w1c),
    .cnt_flat  (cnt_flat),
    .carry_ff  (carry),
    .overflow  (ovf)
  );

  emc_tx_sched u_sched (
    .pclk        (pclk),
    .presetn     (presetn),
    .data_ready  (tx_data_ready),
    .tx_stop     (gts_ff || rx_pause_active || halted_ff),
    .pause_req   (pause_req_ff),
    .pause_time  (ptv_ff),
    .halt_clr    (!halted_ff),
    .rsp         (tx_rsp),
    .cmd_ff      (tx_cmd),
    .pause_sent  (pause_sent),
    .retry_abort (retry_abort),
    .halted      (sched_halted)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (cnt_sel) begin
      prdata = 32'(cnt_flat[cnt_idx*CNT_W +: CNT_W]);
    end else begin
      case (paddr)
        `EMC_OFF_ECTRL:   prdata = ectrl_ff;
        `EMC_OFF_DMA_CONTROL_REG: prdata = 32'({gts_ff, 3'b000});
        `EMC_OFF_TRANSMIT_CONTROL_REG:   prdata = 32'({pause_req_ff, 4'h0}); // [R15]
        `EMC_OFF_PTV:     prdata = 32'(ptv_ff);
        `EMC_OFF_TRANSMIT_STATUS_REG:   prdata = 32'({sched_halted, halted_ff});
        `EMC_OFF_INTERRUPT_EVENT_REG:  prdata = 32'(interrupt_event_reg_ff);
        `EMC_OFF_CARRY1:  prdata = 32'(carry[NCNT/2-1:0]);
        `EMC_OFF_CARRY2:  prdata = 32'(carry[NCNT-1:NCNT/2]);
        default:          mapped = 1'b0;
      endcase
    end
  end

  assign pslverr = acc && !mapped;
endmodule

// ===== verification/emc_mac_ctrl_assertions.sv
// Purpose: concurrent checks on the mac control block ports
// Assumes: zero wait apb, one clock domain
// Notes:   frame tracking mirrors the engine's one answer per start
`timescale 1ns/1ps
module emc_mac_ctrl_chk import emc_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire emc_tx_rsp_t tx_rsp,
  input wire emc_tx_cmd_t tx_cmd,
  input wire logic        tx_bd_fetch,
  input wire logic        tx_halted,
  input wire logic        rmii_select,
  input wire logic        receive_error_input,
  input wire logic        rgmii_or_rtbi,
  input wire logic        rx_error_seen,
  input wire logic        mgmt_write_done,
  input wire logic        mgmt_read_done,
  input wire logic        special_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        wr, rd, busy_ff, pfl_ff, pend_ff;
  logic [15:0] ptv_ff;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ptv_ff <= 16'h0000;
    else if (wr && paddr == 12'h00c) ptv_ff <= pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'h0;
      pfl_ff  <= 1'h0;
    end else if (tx_cmd.start) begin
      busy_ff <= 1'h1;
      pfl_ff  <= tx_cmd.is_pause;
    end else if (tx_rsp.done || tx_rsp.retry_limit) busy_ff <= 1'h0;
  end
  // a fresh request in the completing cycle wins over the self-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_ff <= 1'h0;
    else if (wr && paddr == 12'h008 && pwdata[4]) pend_ff <= 1'h1;
    else if (busy_ff && pfl_ff && tx_rsp.done) pend_ff <= 1'h0;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence pause_go;
    tx_cmd.start && tx_cmd.is_pause;
  endsequence
  sequence fetch_pulse;
    tx_bd_fetch ##1 !tx_bd_fetch;
  endsequence
  fetch_now_a: assert property (wr && paddr == 12'h004 && pwdata[2] |=> fetch_pulse)
    else $error("no single fetch pulse after on-demand write");
  rmii_sel_a: assert property (wr && paddr == 12'h000 |=> rmii_select == $past(pwdata[0] && !pwdata[2]))
    else $error("rmii select does not follow its bit");
  rx_err_gate_a: assert property (rx_error_seen == (receive_error_input && !rgmii_or_rtbi))
    else $error("receive error gating wrong");
  one_frame_a: assert property (tx_cmd.start |-> !busy_ff)
    else $error("frame started while another in flight");
  data_held_a: assert property (pend_ff && $past(pend_ff) && tx_cmd.start |-> tx_cmd.is_pause)
    else $error("data frame started while pause pending");
  pause_time_a: assert property (pause_go |-> tx_cmd.pause_time == ptv_ff)
    else $error("pause frame carries wrong time");
  req_read_a: assert property (rd && paddr == 12'h008 |-> prdata[4] == pend_ff)
    else $error("pause request bit reads wrong");
  halt_set_a: assert property (busy_ff && !pfl_ff && tx_rsp.retry_limit |=> tx_halted)
    else $error("queue not halted after retry limit");
  halt_hold_a: assert property (tx_halted |-> !(tx_cmd.start && !tx_cmd.is_pause))
    else $error("data frame started while halted");
  special_ev_a: assert property (mgmt_write_done || mgmt_read_done |=> special_event)
    else $error("management done not flagged as special event");
endmodule

bind emc_mac_ctrl emc_mac_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .tx_rsp, .tx_cmd, .tx_bd_fetch, .tx_halted, .rmii_select, .receive_error_input, .rgmii_or_rtbi, .rx_error_seen,
  .mgmt_write_done, .mgmt_read_done, .special_event);

// ===== verification/emc_frame_engine.sv
// Purpose: behavioural frame engine answering transmit commands
// Assumes: one start at a time
// Notes:   frame length and collision abort are set by the bench
`timescale 1ns/1ps
module emc_frame_engine import emc_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire emc_tx_cmd_t tx_cmd,
  input wire logic [3:0]  dly,
  input wire logic        fail,
  output emc_tx_rsp_t     tx_rsp
);
  logic       busy_ff, pause_ff;
  logic [3:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff  <= 1'h0;
      pause_ff <= 1'h0;
      cnt_ff   <= 4'h0;
      tx_rsp   <= '0;
    end else begin
      tx_rsp <= '0;
      if (tx_cmd.start) begin
        busy_ff  <= 1'h1;
        pause_ff <= tx_cmd.is_pause;
        cnt_ff   <= dly;
      end else if (busy_ff && cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
      else if (busy_ff) begin
        busy_ff <= 1'h0;
        // aborts are only ever applied to data frames
        tx_rsp.done        <= !(fail && !pause_ff);
        tx_rsp.retry_limit <= fail && !pause_ff;
      end
    end
  end
endmodule

// ===== verification/ethernet_mac_pause_and_counters_test.sv
// Purpose: directed apb test of the mac control block
// Assumes: frame engine answers each start after dly+1 cycles
// Notes:   software side keeps the mode bit and auto zero rules
`timescale 1ns/1ps
module ethernet_mac_pause_and_counters_test import emc_pkg::*; ;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, fail = 1'h0;
  logic [7:0]  stat_inc = 8'h00;
  logic        tx_data_ready = 1'h0, rx_pause_active = 1'h0, mgmt_write_done = 1'h0, mgmt_read_done = 1'h0;
  logic        receive_error_input = 1'h0, rgmii_or_rtbi = 1'h0;
  emc_tx_rsp_t tx_rsp;
  emc_tx_cmd_t tx_cmd;
  logic        tx_bd_fetch, tx_halted, rmii_select, tbi_select, gmii_select, rx_error_seen, special_event;
  logic [15:0] last_ptv;
  int          miscompares = 0, num_checks = 0, n_data = 0, n_pause = 0, k;
  always #50 pclk = ~pclk;
  emc_mac_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stat_inc, .tx_data_ready, .tx_rsp, .rx_pause_active, .mgmt_write_done, .mgmt_read_done, .receive_error_input,
    .rgmii_or_rtbi, .tx_cmd, .tx_bd_fetch, .tx_halted, .rmii_select, .tbi_select, .gmii_select, .rx_error_seen,
    .special_event);
  emc_frame_engine eng (.pclk, .presetn, .tx_cmd, .dly(4'h8), .fail, .tx_rsp);
  always @(posedge pclk) begin
    if (presetn && tx_cmd.start === 1'h1) begin
      if (tx_cmd.is_pause) begin
        n_pause++;
        last_ptv = tx_cmd.pause_time;
      end else n_data++;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail_wait();
    miscompares++;
    end_of_test();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) fail_wait();
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic wait_until(ref int cnt, input int tgt);
    for (int i = 0; i < 300 && cnt < tgt; i++) @(posedge pclk);
    if (cnt < tgt) fail_wait();
  endtask
  task automatic bump(input int i, input int n);
    repeat (n) begin
      @(posedge pclk);
      stat_inc[i] <= 1'h1;
      @(posedge pclk);
      stat_inc[i] <= 1'h0;
    end
  endtask
  task automatic wrap1();
    wr(12'h104, 32'hffff_ffff);
    bump(1, 1);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    // one mode bit at a time: rmii never with reduced pin mode, gmii alone
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, (i == 0) ? 32'h1 : 32'h10 << (i - 1));
      #1 chk({29'h0, rmii_select, tbi_select, gmii_select}, 32'h4 >> i);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      rgmii_or_rtbi       <= i[0];
      receive_error_input <= 1'h1;
      @(posedge pclk);
      #1 chk(32'(rx_error_seen), 32'(!i[0]));
    end
    wr(12'h000, 32'h0);
    bump(0, 3);
    rd(12'h100, 32'h3);
    rd(12'h100, 32'h3);
    wrap1();
    rd(12'h104, 32'h0);
    rd(12'h018, 32'h2);
    chk(32'(special_event), 32'h1);
    wr(12'h018, 32'h0);
    rd(12'h018, 32'h2);
    wr(12'h000, 32'h1000);
    rd(12'h018, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h000, 32'h0);
    wrap1();
    wr(12'h018, 32'h2);
    rd(12'h018, 32'h0);
    // auto zero is set while no frame traffic runs
    wr(12'h000, 32'h800);
    bump(2, 2);
    rd(12'h108, 32'h2);
    rd(12'h108, 32'h0);
    wr(12'h000, 32'h0);
    wr(12'h014, 32'h1f);
    #1 chk(32'(special_event), 32'h0);
    @(posedge pclk);
    mgmt_write_done <= 1'h1;
    mgmt_read_done  <= 1'h1;
    @(posedge pclk);
    mgmt_write_done <= 1'h0;
    mgmt_read_done  <= 1'h0;
    rd(12'h014, 32'h18);
    wr(12'h014, 32'h1f);
    wr(12'h020, 32'hffff_ffff);
    rd(12'h020, 32'h0);
    chk(32'(e), 32'h1);
    wr(12'h004, 32'h4);
    #1 chk(32'(tx_bd_fetch), 32'h1);
    rd(12'h004, 32'h0);
    tx_data_ready <= 1'h1;
    wait_until(n_data, 1);
    wr(12'h00c, 32'h1234);
    wr(12'h008, 32'h10);
    rd(12'h008, 32'h10);
    wait_until(n_pause, 1);
    chk(32'(last_ptv), 32'h1234);
    k = n_data;
    wait_until(n_data, k + 1);
    rd(12'h008, 32'h0);
    rd(12'h014, 32'h1);
    for (int m = 0; m < 2; m++) begin
      if (m == 0) wr(12'h004, 32'h8);
      else begin
        wr(12'h004, 32'h0);
        rx_pause_active <= 1'h1;
      end
      repeat (20) @(posedge pclk);
      k = n_data;
      wr(12'h008, 32'h10);
      wait_until(n_pause, m + 2);
      repeat (20) @(posedge pclk);
      chk(32'(n_data), 32'(k));
      rd(12'h008, 32'h0);
    end
    rx_pause_active <= 1'h0;
    fail            <= 1'h1;
    k = n_data;
    wait_until(n_data, k + 1);
    repeat (12) @(posedge pclk);
    chk(32'(tx_halted), 32'h1);
    rd(12'h010, 32'h3);
    rd(12'h014, 32'h3);
    chk(32'(n_data), 32'(k + 1));
    fail <= 1'h0;
    wr(12'h010, 32'h1);
    #1 chk(32'(tx_halted), 32'h0);
    end_of_test();
  end
endmodule
